//--- ckc_ctrl.sv
// clock source selection, prescaler, peripheral gating and sleep control
// assumes software strobes are one-cycle pulses and inputs are synchronous
`default_nettype none

module ckc_ctrl #(
	parameter int NPER = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic osc_en_wr,
	input wire logic [ckc_pkg::NOSC-1:0] osc_en_req,
	input wire logic src_wr,
	input wire logic [2:0] src_req,
	input wire logic psc_wr,
	input wire logic [3:0] psc_req,
	input wire logic pll_fac_wr,
	input wire logic [4:0] pll_fac_req,
	input wire logic xosc_mode_wr,
	input wire logic [1:0] xosc_mode_req,
	input wire logic cal_wr,
	input wire logic [7:0] cal_req,
	input wire logic fail_mon_en,
	input wire logic xosc_fail,
	input wire logic pll_fail,
	input wire logic rtc_en,
	input wire logic rtc_src_lp,
	input wire logic wdt_en,
	input wire logic [NPER-1:0] per_gate,
	input wire logic sleep_en,
	input wire logic [2:0] sleep_mode,
	input wire logic sleep_instr,
	input wire logic nvm_busy,
	input wire logic irq_any,
	input wire logic irq_twi_match,
	input wire logic irq_port_async,
	input wire logic irq_rtc,
	output logic [ckc_pkg::NOSC-1:0] osc_run,
	output logic lp_osc_en,
	output logic [2:0] sysclk_src,
	output logic [3:0] psc_sel,
	output logic [4:0] pll_fac,
	output logic [1:0] xosc_mode,
	output logic [7:0] rc32k_cal,
	output logic fail_nmi,
	output logic cpu_clk_en,
	output logic nvm_clk_en,
	output logic [NPER-1:0] per_clk_en,
	output logic rtc_clk_en,
	output logic lp_1k_tick,
	output logic rc32k_tick,
	output logic rc32k_1k_tick,
	output logic cpu_halt,
	output logic sleeping,
	output logic wake
);
	import ckc_pkg::*;

	ckc_state_t state_r;
	ckc_state_t state_nxt;
	logic [NOSC-1:0] osc_en_r;
	logic [2:0] src_pend_r;
	logic src_pend_v_r;
	logic [3:0] psc_pend_r;
	logic psc_pend_v_r;
	logic [10:0] psc_cnt_r;
	logic [10:0] psc_mask;
	logic sys_edge;
	logic [NPER-1:0] per_gate_r;
	logic [2:0] mode_r;
	logic [2:0] halt_cnt_r;
	logic fail_hit;
	logic [NOSC-1:0] fail_bits;
	logic per_run;
	logic rtc_run;
	logic osc_keep;
	logic wake_src;
	logic cpu_run;
	logic mode_ok;
	logic lp_tick;
	logic lp_1k;
	logic rc_tick;
	logic rc_1k;

	// ==========================================================
	// low-rate oscillator models and their built-in prescalers
	ckc_tick_div #(
		.DIV(LP_DIV)
	) u_lp_osc (
		.clk(clk),
		.sys_rst(sys_rst),
		.en(lp_osc_en),
		.tick(lp_tick)
	);

	// 1 kHz tap of the low-power oscillator
	ckc_tick_div #(
		.DIV(LOW_DIV)
	) u_lp_1k (
		.clk(clk),
		.sys_rst(sys_rst),
		.en(lp_tick),
		.tick(lp_1k)
	);

	ckc_tick_div #(
		.DIV(RC32K_DIV)
	) u_rc32k (
		.clk(clk),
		.sys_rst(sys_rst),
		.en(osc_run[OSC_RC32K]),
		.tick(rc_tick)
	);

	// 1.024 kHz tap of the calibrated 32.768 kHz oscillator
	ckc_tick_div #(
		.DIV(LOW_DIV)
	) u_rc32k_1k (
		.clk(clk),
		.sys_rst(sys_rst),
		.en(rc_tick),
		.tick(rc_1k)
	);

	// ==========================================================
	// system prescaler: divide by two to the power of psc_sel
	assign psc_mask = 11'((12'h001 << psc_sel) - 12'h001);
	assign sys_edge = ((psc_cnt_r & psc_mask) == 11'h000);

	// free-running prescaler counter
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			psc_cnt_r <= 11'h000;
		else
			psc_cnt_r <= psc_cnt_r + 11'h001;
	end

	// ==========================================================
	// oscillator failure detection
	assign fail_bits = {pll_fail & osc_en_r[OSC_PLL],
		xosc_fail & osc_en_r[OSC_XOSC], 3'h0};
	assign fail_hit = fail_mon_en & (|fail_bits);

	// one-cycle NMI: the failed source is dropped at once
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			fail_nmi <= 1'b0;
		else
			fail_nmi <= fail_hit;
	end

	// ==========================================================
	// oscillator enables; the selected source cannot be turned off
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			osc_en_r <= OSC_EN_RST;
		else if (fail_hit)
			osc_en_r <= (osc_en_r & ~fail_bits) | OSC_EN_RST;
		else if (osc_en_wr)
			osc_en_r <= osc_en_req | NOSC'(5'h01 << sysclk_src);
	end

	// ==========================================================
	// source and prescaler changes, staged to a clock boundary
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sysclk_src <= SRC_RST;
			src_pend_r <= SRC_RST;
			src_pend_v_r <= 1'b0;
		end
		else if (fail_hit)
		begin
			sysclk_src <= SRC_RST;
			src_pend_v_r <= 1'b0;
		end
		else if (src_wr && src_req <= SRC_LAST && osc_en_r[src_req])
		begin
			src_pend_r <= src_req;
			src_pend_v_r <= 1'b1;
		end
		else if (src_pend_v_r && sys_edge)
		begin
			sysclk_src <= src_pend_r;
			src_pend_v_r <= 1'b0;
		end
	end

	// prescaler select, out-of-range values ignored
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			psc_sel <= PSC_RST;
			psc_pend_r <= PSC_RST;
			psc_pend_v_r <= 1'b0;
		end
		else if (psc_wr && psc_req <= PSC_MAX)
		begin
			psc_pend_r <= psc_req;
			psc_pend_v_r <= 1'b1;
		end
		else if (psc_pend_v_r && sys_edge)
		begin
			psc_sel <= psc_pend_r;
			psc_pend_v_r <= 1'b0;
		end
	end

	// ==========================================================
	// PLL factor, crystal range and calibration settings
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			pll_fac <= PLL_FAC_RST;
		else if (pll_fac_wr && pll_fac_req >= PLL_FAC_MIN)
			pll_fac <= pll_fac_req;
	end

	// crystal range mode, all four codes legal
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			xosc_mode <= XOSC_MODE_RST;
		else if (xosc_mode_wr)
			xosc_mode <= xosc_mode_req;
	end

	// calibration of the 32.768 kHz oscillator
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			rc32k_cal <= CAL_RST;
		else if (cal_wr)
			rc32k_cal <= cal_req;
	end

	// ==========================================================
	// what keeps running in each sleep mode, and what wakes it
	always_comb
	begin
		per_run = 1'b1;
		rtc_run = rtc_en;
		osc_keep = 1'b1;
		wake_src = 1'b0;
		if (state_r == ST_SLEEP)
		begin
			unique case (mode_r)
				SM_IDLE:
				begin
					wake_src = irq_any;
				end
				SM_PDOWN:
				begin
					per_run = 1'b0;
					rtc_run = 1'b0;
					osc_keep = 1'b0;
					wake_src = irq_twi_match | irq_port_async;
				end
				SM_PSAVE:
				begin
					per_run = 1'b0;
					osc_keep = 1'b0;
					wake_src = irq_twi_match | irq_port_async
						| (irq_rtc & rtc_en);
				end
				SM_STDBY:
				begin
					per_run = 1'b0;
					rtc_run = 1'b0;
					wake_src = irq_twi_match | irq_port_async;
				end
				SM_ESTDBY:
				begin
					per_run = 1'b0;
					wake_src = irq_twi_match | irq_port_async
						| (irq_rtc & rtc_en);
				end
				default:
				begin
					wake_src = irq_any;
				end
			endcase
		end
	end

	assign mode_ok = (sleep_mode == SM_IDLE) || (sleep_mode == SM_PDOWN)
		|| (sleep_mode == SM_PSAVE) || (sleep_mode == SM_STDBY)
		|| (sleep_mode == SM_ESTDBY);

	// ==========================================================
	// power state transitions
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_ACTIVE:
				if (sleep_instr && sleep_en && mode_ok)
					state_nxt = ST_NVMWAIT;
			ST_NVMWAIT:
				if (!nvm_busy)
					state_nxt = ST_SLEEP;
			ST_SLEEP:
				if (wake_src)
					state_nxt = ST_HALT;
			ST_HALT:
				if (sys_edge && halt_cnt_r == HALT_CYC - 3'h1)
					state_nxt = ST_ACTIVE;
		endcase
	end

	// state register; reset from any state restarts in active
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			state_r <= ST_ACTIVE;
		else
			state_r <= state_nxt;
	end

	// latch the configured mode at sleep entry
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			mode_r <= SM_IDLE;
		else if (state_r == ST_ACTIVE && state_nxt == ST_NVMWAIT)
			mode_r <= sleep_mode;
	end

	// count CPU cycles of the post-wake halt
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			halt_cnt_r <= 3'h0;
		else if (state_r != ST_HALT)
			halt_cnt_r <= 3'h0;
		else if (sys_edge)
			halt_cnt_r <= halt_cnt_r + 3'h1;
	end

	// status towards CPU and interrupt controller
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cpu_halt <= 1'b0;
			sleeping <= 1'b0;
			wake <= 1'b0;
		end
		else
		begin
			cpu_halt <= (state_nxt != ST_ACTIVE);
			sleeping <= (state_nxt == ST_SLEEP);
			// wake pulse lets the interrupt controller order service
			wake <= (state_r == ST_SLEEP) && wake_src;
		end
	end

	// ==========================================================
	// clock enables; gating changes only at a system clock boundary
	assign cpu_run = (state_r == ST_ACTIVE) || (state_r == ST_HALT);

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			per_gate_r <= '0;
		else if (sys_edge)
			per_gate_r <= per_gate;
	end

	// enable pulses; held state stays frozen without them
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cpu_clk_en <= 1'b0;
			nvm_clk_en <= 1'b0;
			per_clk_en <= '0;
			rtc_clk_en <= 1'b0;
		end
		else
		begin
			cpu_clk_en <= sys_edge & cpu_run;
			// next state, so the memory clock is already off when sleeping rises
			nvm_clk_en <= sys_edge & (state_nxt != ST_SLEEP);
			per_clk_en <= {NPER{sys_edge & per_run}} & ~per_gate_r;
			rtc_clk_en <= rtc_run & (rtc_src_lp ? lp_1k : rc_1k);
		end
	end

	// ==========================================================
	// oscillator run lines as seen by the analog cells
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			osc_run <= OSC_EN_RST;
			lp_osc_en <= LP_EN_RST;
		end
		else
		begin
			osc_run <= (osc_keep ? osc_en_r : '0)
				| (NOSC'(rtc_run & ~rtc_src_lp) << OSC_RC32K);
			lp_osc_en <= wdt_en | (rtc_run & rtc_src_lp);
		end
	end

	// low-rate taps brought out registered
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lp_1k_tick <= 1'b0;
			rc32k_tick <= 1'b0;
			rc32k_1k_tick <= 1'b0;
		end
		else
		begin
			lp_1k_tick <= lp_1k;
			rc32k_tick <= rc_tick;
			rc32k_1k_tick <= rc_1k;
		end
	end

endmodule : ckc_ctrl

`default_nettype wire

//--- ckc_pkg.sv
// constants, encodings and state type of the clock and sleep controller
// assumes a single 25 MHz clk; every slower rate is an enable pulse
//
// Contract
// - any reset switches off every clock source except the 2 MHz oscillator and the low-power 32 kHz one
// - after reset system clock is the 2 MHz oscillator, everything else off
// - software may change system clock source and prescaler at any time
// - monitored oscillator or PLL failure raises NMI, falls back internally
// - low-power oscillator runs only while used; prescaler gives 1 kHz tick
// - calibrated 32.768 kHz oscillator takes calibration writes; full and 1.024 kHz
// - PLL factor selectable 1 to 31, feeding system clock via prescalers
// - crystal oscillator has four selectable frequency range modes
// - a gated-off peripheral clock freezes that peripheral until restored
// - sleep instruction enters whichever of five sleep modes is configured
// - wake interrupt serviced after higher priority ones, then resume after sleep
// - after every wake-up the CPU is held halted for four cycles
// - sleep keeps all state; reset during sleep gives full restart
// - idle stops CPU and memory clocks after programming ends; interrupts wake
// - power-down stops all clocks; only address-match and async port wake
// - power-save as power-down but enabled RTC runs and its interrupt wakes
// - standby as power-down but enabled system oscillators keep running
// - extended standby as power-save with enabled system oscillators running
`default_nettype none

package ckc_pkg;

	// ==========================================================
	// timing
	localparam int CLK_HZ = 25_000_000;
	localparam int LP_OSC_HZ = 32_000;
	localparam int RC32K_HZ = 32_768;
	localparam int LP_DIV = CLK_HZ / LP_OSC_HZ;
	localparam int RC32K_DIV = CLK_HZ / RC32K_HZ;
	localparam int LOW_DIV = 32;
	localparam logic [2:0] HALT_CYC = 3'h4;

	// ==========================================================
	// oscillator indices, also the source select codes
	localparam int NOSC = 5;
	localparam int OSC_RC2M = 0;
	localparam int OSC_RC32M = 1;
	localparam int OSC_RC32K = 2;
	localparam int OSC_XOSC = 3;
	localparam int OSC_PLL = 4;
	localparam logic [2:0] SRC_LAST = 3'h4;

	// ==========================================================
	// reset values and write limits
	localparam logic [4:0] OSC_EN_RST = 5'h01;
	localparam logic [2:0] SRC_RST = 3'h0;
	localparam logic [3:0] PSC_RST = 4'h0;
	localparam logic [3:0] PSC_MAX = 4'hB;
	localparam logic [4:0] PLL_FAC_RST = 5'h01;
	localparam logic [4:0] PLL_FAC_MIN = 5'h01;
	localparam logic [1:0] XOSC_MODE_RST = 2'h0;
	localparam logic [7:0] CAL_RST = 8'h80;
	localparam logic LP_EN_RST = 1'b1;

	// ==========================================================
	// sleep mode codes
	localparam logic [2:0] SM_IDLE = 3'h0;
	localparam logic [2:0] SM_PDOWN = 3'h2;
	localparam logic [2:0] SM_PSAVE = 3'h3;
	localparam logic [2:0] SM_STDBY = 3'h6;
	localparam logic [2:0] SM_ESTDBY = 3'h7;

	// ==========================================================
	// power state machine
	typedef enum logic [3:0] {
		ST_ACTIVE = 4'b0001,
		ST_NVMWAIT = 4'b0010,
		ST_SLEEP = 4'b0100,
		ST_HALT = 4'b1000
	} ckc_state_t;

endpackage : ckc_pkg

`default_nettype wire

//--- ckc_tick_div.sv
// enable-pulse divider: one tick every DIV enabled cycles
// assumes en is a single-cycle qualifier in the clk domain
`default_nettype none

module ckc_tick_div #(
	parameter int DIV = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic en,
	output logic tick
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	logic [W-1:0] cnt_r;

	// ==========================================================
	// count enabled cycles, pulse on wrap
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_r <= '0;
			tick <= 1'b0;
		end
		else if (en)
		begin
			tick <= (cnt_r == LAST);
			cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
		end
		else
		begin
			tick <= 1'b0;
		end
	end

endmodule : ckc_tick_div

`default_nettype wire

//--- ckc_ctrl_properties.sv
// port-level timing relations of the clock and sleep controller
// assumes a bind onto ckc_ctrl, one clk domain, sys_rst active high
`default_nettype none

module ckc_ctrl_checker #(
	parameter int NPER = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pll_fac_wr,
	input wire logic [4:0] pll_fac_req,
	input wire logic cal_wr,
	input wire logic [7:0] cal_req,
	input wire logic irq_any,
	input wire logic irq_twi_match,
	input wire logic irq_port_async,
	input wire logic irq_rtc,
	input wire logic [2:0] sysclk_src,
	input wire logic [3:0] psc_sel,
	input wire logic [4:0] pll_fac,
	input wire logic [7:0] rc32k_cal,
	input wire logic fail_nmi,
	input wire logic cpu_clk_en,
	input wire logic nvm_clk_en,
	input wire logic cpu_halt,
	input wire logic sleeping,
	input wire logic wake
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// settings
	a_pll_write: assert property (
		pll_fac_wr && pll_fac_req != 5'h00 |=> pll_fac == $past(pll_fac_req))
		else $error("pll factor not loaded");
	a_pll_range: assert property (pll_fac != 5'h00)
		else $error("pll factor zero");
	a_cal_write: assert property (
		cal_wr |=> rc32k_cal == $past(cal_req))
		else $error("calibration not loaded");
	a_psc_range: assert property (psc_sel <= 4'hB && sysclk_src <= 3'h4)
		else $error("prescaler or source out of range");
	a_fail_fallback: assert property (
		fail_nmi |-> sysclk_src == 3'h0 ##1 !fail_nmi)
		else $error("no fallback on failure");

	// ==========================================================
	// sleep and wake
	a_sleep_cpu_stop: assert property (
		sleeping |-> !cpu_clk_en && !nvm_clk_en)
		else $error("cpu clock runs in sleep");
	a_wake_cause: assert property (
		wake |-> $past(sleeping) && !sleeping
			&& $past(irq_any | irq_twi_match | irq_port_async | irq_rtc))
		else $error("wake without sleep or interrupt");
	a_wake_halt: assert property (wake |-> cpu_halt [*4])
		else $error("cpu released early after wake");

	c_wake: cover property (wake);
	c_fail: cover property (fail_nmi);
	c_sleep: cover property ($rose(sleeping));
endmodule : ckc_ctrl_checker

bind ckc_ctrl ckc_ctrl_checker #(.NPER(NPER)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .pll_fac_wr(pll_fac_wr),
	.pll_fac_req(pll_fac_req), .cal_wr(cal_wr), .cal_req(cal_req),
	.irq_any(irq_any), .irq_twi_match(irq_twi_match),
	.irq_port_async(irq_port_async), .irq_rtc(irq_rtc),
	.sysclk_src(sysclk_src), .psc_sel(psc_sel), .pll_fac(pll_fac),
	.rc32k_cal(rc32k_cal), .fail_nmi(fail_nmi), .cpu_clk_en(cpu_clk_en),
	.nvm_clk_en(nvm_clk_en), .cpu_halt(cpu_halt), .sleeping(sleeping),
	.wake(wake));

`default_nettype wire

//--- ckc_core_model.sv
// stand-in for the cpu core and one gated peripheral
// assumes clock enables are one-cycle pulses in the clk domain
`default_nettype none

module ckc_core_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cpu_clk_en,
	input wire logic cpu_halt,
	input wire logic per_clk_en,
	output logic [15:0] instr_cnt_r,
	output logic [7:0] per_cnt_r
);
	timeunit 1ns;
	timeprecision 1ps;
	// instructions advance only on an enabled, unhalted cpu
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			instr_cnt_r <= 16'h0000;
		else if (cpu_clk_en && !cpu_halt)
			instr_cnt_r <= instr_cnt_r + 16'h0001;

	// peripheral state moves only on its own clock enable
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			per_cnt_r <= 8'h00;
		else if (per_clk_en)
			per_cnt_r <= per_cnt_r + 8'h01;
endmodule : ckc_core_model

`default_nettype wire

//--- test_clock_source_and_sleep_control.sv
// self-checking bench for the clock source and sleep controller
// assumes ckc_pkg, ckc_ctrl, its checker and the core model compiled first
`default_nettype none

module test_clock_source_and_sleep_control;
	timeunit 1ns;
	timeprecision 1ps;
	import ckc_pkg::*;
	logic clk, sys_rst, osc_en_wr, src_wr, psc_wr, pll_fac_wr;
	logic xosc_mode_wr, cal_wr, fail_mon_en, xosc_fail, pll_fail;
	logic rtc_en, rtc_src_lp, wdt_en, sleep_en, sleep_instr, nvm_busy;
	logic irq_any, irq_twi_match, irq_port_async, irq_rtc;
	logic [4:0] osc_en_req, pll_fac_req, osc_run, pll_fac;
	logic [2:0] src_req, sleep_mode, sysclk_src, m;
	logic [3:0] psc_req, psc_sel;
	logic [1:0] xosc_mode_req, xosc_mode;
	logic [7:0] cal_req, rc32k_cal, per_gate, per_clk_en, per_cnt, p;
	logic lp_osc_en, fail_nmi, cpu_clk_en, nvm_clk_en, rtc_clk_en;
	logic lp_1k_tick, rc32k_tick, rc32k_1k_tick, cpu_halt, sleeping, wake;
	logic [15:0] instr_cnt, c;
	int failures, tests_run, exp_pll, seed, n;
	logic [2:0] modes[$];

	ckc_ctrl #(.NPER(8)) dut (.*);
	ckc_core_model core (.clk(clk), .sys_rst(sys_rst),
		.cpu_clk_en(cpu_clk_en), .cpu_halt(cpu_halt),
		.per_clk_en(per_clk_en[0]), .instr_cnt_r(instr_cnt),
		.per_cnt_r(per_cnt));

	// ==========================================================
	// clock and helpers
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wait_sleep;
		for (int i = 0; i < 40 && sleeping !== 1'b1; i++) cyc(1);
	endtask : wait_sleep

	task automatic set_psc(input logic [3:0] v);
		psc_req = v;
		psc_wr = 1'b1;
		cyc(1);
		psc_wr = 1'b0;
		for (int i = 0; i < 4200 && psc_sel !== v; i++) cyc(1);
	endtask : set_psc

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	// watchdog against a hung handshake
	initial
	begin
		repeat (30000) @(posedge clk);
		failures++;
		$display("ERROR %0t run did not finish", $time);
		test_done;
	end

	// ==========================================================
	// main sequence
	initial
	begin
		{osc_en_wr, src_wr, psc_wr, pll_fac_wr, xosc_mode_wr, cal_wr} = '0;
		{fail_mon_en, xosc_fail, pll_fail, rtc_en, rtc_src_lp} = '0;
		{wdt_en, sleep_en, sleep_instr, nvm_busy} = '0;
		{irq_any, irq_twi_match, irq_port_async, irq_rtc} = '0;
		{osc_en_req, pll_fac_req, src_req, sleep_mode} = '0;
		{psc_req, xosc_mode_req, cal_req, per_gate} = '0;
		modes = '{SM_IDLE, SM_PDOWN, SM_PSAVE, SM_STDBY, SM_ESTDBY};
		failures = 0;
		tests_run = 0;
		exp_pll = 1;
		seed = $urandom(44);
		sys_rst = 1'b1;
		cyc(20);
		check(osc_run, 8'h01);
		check(lp_osc_en, 8'h01);
		check(sysclk_src, 8'h00);
		sys_rst = 1'b0;
		cyc(2);
		check(lp_osc_en, 8'h00);
		check(osc_run, 8'h01);
		wdt_en = 1'b1;
		cyc(2);
		check(lp_osc_en, 8'h01);
		// factors back to back, zero refused
		pll_fac_wr = 1'b1;
		for (int f = 0; f < 32; f++)
		begin
			pll_fac_req = f[4:0];
			cyc(1);
			if (f != 0) exp_pll = f;
			check(pll_fac, exp_pll[7:0]);
		end
		pll_fac_wr = 1'b0;
		xosc_mode_wr = 1'b1;
		cal_wr = 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			xosc_mode_req = k[1:0];
			cal_req = 8'($urandom);
			cyc(1);
			check(xosc_mode, k[7:0]);
			check(rc32k_cal, cal_req);
		end
		{xosc_mode_wr, cal_wr} = '0;
		// peripheral freeze while gated
		per_gate = 8'($urandom) | 8'h01;
		cyc(3);
		p = per_cnt;
		cyc(10);
		check(per_cnt, p);
		per_gate = 8'h00;
		cyc(4);
		check(per_cnt != p, 8'h01);
		// source and prescaler switch
		osc_en_req = 5'h0B;
		osc_en_wr = 1'b1;
		cyc(1);
		osc_en_wr = 1'b0;
		src_req = 3'h3;
		src_wr = 1'b1;
		cyc(1);
		src_wr = 1'b0;
		cyc(1);
		check(sysclk_src, 8'h03);
		p = 8'($urandom_range(11));
		set_psc(p[3:0]);
		check(psc_sel, p);
		set_psc(4'h0);
		check(psc_sel, 8'h00);
		// monitored failure, then one on a disabled source
		fail_mon_en = 1'b1;
		xosc_fail = 1'b1;
		cyc(1);
		check(fail_nmi, 8'h01);
		check(sysclk_src, 8'h00);
		xosc_fail = 1'b0;
		cyc(1);
		check(osc_run[3], 8'h00);
		check(fail_nmi, 8'h00);
		pll_fail = 1'b1;
		cyc(3);
		check(fail_nmi, 8'h00);
		pll_fail = 1'b0;
		// calibrated oscillator started by the rtc, full-rate tick counted
		rtc_en = 1'b1;
		cyc(2);
		check(osc_run[OSC_RC32K], 8'h01);
		n = 0;
		repeat (2 * RC32K_DIV + 40)
		begin
			cyc(1);
			n += rc32k_tick;
		end
		check(n[7:0], 8'h02);
		// undefined mode code refused
		sleep_mode = 3'h1;
		sleep_en = 1'b1;
		sleep_instr = 1'b1;
		cyc(1);
		sleep_instr = 1'b0;
		check(cpu_halt, 8'h00);
		// every sleep mode with accepted wake sources, and refused ones outside idle
		foreach (modes[i])
		begin
			m = modes[i];
			sleep_mode = m;
			sleep_en = 1'b1;
			nvm_busy = (m == SM_IDLE);
			sleep_instr = 1'b1;
			cyc(1);
			sleep_instr = 1'b0;
			cyc(3);
			check(sleeping, m != SM_IDLE);
			nvm_busy = 1'b0;
			wait_sleep;
			check(sleeping, 8'h01);
			c = instr_cnt;
			irq_any = (m != SM_IDLE);
			irq_rtc = (m == SM_PDOWN || m == SM_STDBY);
			cyc(3);
			check(wake, 8'h00);
			check(instr_cnt[7:0], c[7:0]);
			check(|per_clk_en, m == SM_IDLE);
			irq_any = (m == SM_IDLE);
			irq_rtc = (m == SM_PSAVE || m == SM_ESTDBY);
			irq_twi_match = (m == SM_PDOWN);
			irq_port_async = (m == SM_STDBY);
			cyc(1);
			check(wake, 8'h01);
			{irq_any, irq_rtc, irq_twi_match, irq_port_async} = '0;
			for (int k = 0; k < 5; k++)
			begin
				check(cpu_halt, k < 4);
				cyc(1);
			end
			check(instr_cnt[7:0], 8'(c[7:0] + 8'h01));
		end
		// reset in the middle of a sleep
		sleep_mode = SM_PDOWN;
		sleep_instr = 1'b1;
		cyc(1);
		sleep_instr = 1'b0;
		wait_sleep;
		sys_rst = 1'b1;
		cyc(2);
		check(sleeping, 8'h00);
		check(osc_run, 8'h01);
		check(pll_fac, 8'h01);
		sys_rst = 1'b0;
		cyc(2);
		check(lp_osc_en, 8'h01);
		check(cpu_halt, 8'h00);
		test_done;
	end
endmodule : test_clock_source_and_sleep_control

`default_nettype wire
